// [logic/fep_pkg.sv]
// package: sizes, code groups, line levels and state types of the 100 Mb/s coding path
package fep_pkg;
    localparam int NIB_W = 4;
    localparam int SYM_W = 5;
    localparam int WORD_W = 6;
    localparam int PAIR_W = 12;
    localparam int EN_BIT = 5;
    localparam int ER_BIT = 4;
    localparam int LFSR_W = 11;
    localparam int TAP_HI = 10;
    localparam int TAP_LO = 8;
    localparam logic [10:0] LFSR_SEED = 11'h7FF;
    // one link clock edge carries one code bit, so a symbol is five edges
    localparam logic [2:0] SYM_LAST = 3'h4;
    localparam logic [5:0] SYNC_BITS = 6'h3C;
    localparam logic [5:0] SILENT_MAX = 6'h20;
    // control code groups
    localparam logic [4:0] SYM_I = 5'h1F;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [4:0] SYM_H = 5'h04;
    // data code groups, indexed by nibble
    localparam logic [4:0] ENC_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    // words handed to the MAC side: {valid, error, nibble}
    localparam logic [5:0] WORD_END = 6'h00;
    localparam logic [5:0] WORD_BAD_END = 6'h10;
    // three-level line codes and the MLT-3 phases that carry them
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS = 2'h1;
    localparam logic [1:0] LVL_NEG = 2'h3;
    localparam logic [1:0] MLT_PH_POS = 2'h1;
    localparam logic [1:0] MLT_PH_NEG = 2'h3;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_K = 2'b01,
        TX_DATA = 2'b10,
        TX_R = 2'b11
    } fep_tx_state_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_DATA = 2'b01,
        RX_END = 2'b10
    } fep_rx_state_t;

    // returns {valid, nibble}; valid low for a group outside the data table
    function automatic logic [4:0] fepDecode(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (ENC_TAB[i] == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction
endpackage

// [logic/fep_lfsr.sv]
// scrambler key generator: 11-bit side-stream shift register, loadable for alignment
`timescale 1ns/10ps
module fep_lfsr
    import fep_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic inBit,
    output logic key
);
    logic [LFSR_W-1:0] state;
    logic [LFSR_W-1:0] next_state;

    // key is the feedback tap; loading takes the received key instead,
    // which pulls the receiver into the transmitter's phase
    always_comb begin
        key = state[TAP_HI] ^ state[TAP_LO];
        next_state = {state[LFSR_W-2:0], load ? inBit : key};
    end

    // all-ones seed keeps the register out of the stuck all-zero state
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LFSR_SEED;
        end else begin
            state <= next_state;
        end
    end
endmodule

// [logic/fep_buf2.sv]
// small FIFO with valid/ready on both sides, two entries by default
`timescale 1ns/10ps
module fep_buf2
    import fep_pkg::*;
#(
    parameter int W = PAIR_W,
    parameter int DEPTH = 2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] next_wrPtr;
    logic [PW-1:0] next_rdPtr;
    logic [PW:0] count;
    logic [PW:0] next_count;
    logic push;
    logic pop;

    // pointers wrap by overflow, so DEPTH must stay a power of two
    always_comb begin
        inReady = count != FULL;
        outValid = count != '0;
        outData = mem[rdPtr];
        push = inValid && inReady;
        pop = outValid && outReady;
        next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
        next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
        next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end
endmodule

// [logic/fep_pcs_datapath.sv]
// 100 Mb/s coding path: MII nibbles on clk, MLT-3 line symbols on lineClk
`timescale 1ns/10ps
// Notes on behaviour
// - transmit order: 4B/5B code, serialize, scramble, NRZ to NRZI, MLT-3
// - MAC nibbles become a continuous serial stream, one bit per link clock
// - data and control symbols pass the 4B/5B coder before the scrambler
// - scrambled bits are turned into NRZI, then into MLT-3 line levels
// - received MLT-3 levels are turned back into an NRZI stream
// - lock is qualified from NRZI transitions; the receiver runs on lineClk, no clock is recovered
// - NRZI is decoded into NRZ bits on lineClk
// - NRZ stream is de-scrambled, then 4B/5B decoded into data and control
// - decoded nibbles are handed to the MAC as parallel receive words
// - 11-bit shift register, 2047-bit key; receiver uses the same sequence
module fep_pcs_datapath
    import fep_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic lineClk,
    input wire logic txEn,
    input wire logic txEr,
    input wire logic [NIB_W-1:0] txData,
    output logic txReady,
    output logic [NIB_W-1:0] rxData,
    output logic rxDv,
    output logic rxEr,
    output logic rxStrobe,
    output logic rxLock,
    output logic [1:0] txLevel,
    input wire logic [1:0] rxLevel
);
    // MAC side transmit pairing and handshake
    logic [WORD_W-1:0] pairLo, pairHi, next_pairLo, next_pairHi, nibWord;
    logic pairHalf, pairFull, frameOpen, next_pairHalf, next_pairFull, next_frameOpen;
    logic next_txReady, accept, bufInReady, bufOutValid, bufOutReady, busy;
    logic [PAIR_W-1:0] bufOut, txWord, next_txWord;
    logic reqTog, next_reqTog, ackS1, ackS2;
    // MAC side receive
    logic rxS1, rxS2, rxS3, rxEdge, lkS1, next_rxDv, next_rxEr;
    logic [NIB_W-1:0] next_rxData, rxWordNib;
    // link side transmit
    logic lrs1, lineRst, reqS1, reqS2, ackTog, next_ackTog, txTake;
    logic [PAIR_W-1:0] pend, next_pend;
    logic pendValid, next_pendValid, halfSel, next_halfSel;
    logic [WORD_W-1:0] txNib;
    fep_tx_state_t txSt, next_txSt;
    logic [2:0] bitCnt, next_bitCnt;
    logic [SYM_W-1:0] sym, next_sym;
    logic txKey, scrBit, nrzi, next_nrzi;
    logic [1:0] mltPh, next_mltPh, next_txLevel;
    // link side receive
    logic [1:0] prevLvl;
    logic rxNrzi, next_rxNrzi, nrz, plain, rxKey, locked, next_locked;
    logic [5:0] silent, next_silent, match, next_match;
    logic descLock, next_descLock;
    logic [2*SYM_W-1:0] sh10, next_sh10;
    logic [SYM_W-1:0] symIn, dec;
    fep_rx_state_t rxSt, next_rxSt;
    logic [2:0] rxCnt, next_rxCnt;
    logic [WORD_W-1:0] rxWord, next_rxWord;
    logic rxTog, next_rxTog;

    // collect two nibbles into one word; a frame end is a word with valid low,
    // so an odd nibble count leaves the end marker in the upper half
    always_comb begin
        nibWord = {txEn, txEr, txData};
        accept = txReady && (txEn || frameOpen);
        next_pairLo = pairLo;
        next_pairHi = pairHi;
        next_pairHalf = pairHalf;
        next_pairFull = pairFull;
        next_frameOpen = frameOpen;
        if (pairFull && bufInReady) begin
            next_pairFull = 1'b0;
            next_pairHalf = 1'b0;
        end
        if (accept) begin
            next_frameOpen = txEn;
            if (!pairHalf) begin
                next_pairLo = nibWord;
                next_pairHalf = 1'b1;
            end
            if (pairHalf || !txEn) begin
                next_pairHi = nibWord;
                next_pairFull = 1'b1;
            end
        end
        next_txReady = !next_pairFull;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pairLo <= WORD_END;
            pairHi <= WORD_END;
            pairHalf <= 1'b0;
            pairFull <= 1'b0;
            frameOpen <= 1'b0;
            txReady <= 1'b1;
        end else begin
            pairLo <= next_pairLo;
            pairHi <= next_pairHi;
            pairHalf <= next_pairHalf;
            pairFull <= next_pairFull;
            frameOpen <= next_frameOpen;
            txReady <= next_txReady;
        end
    end

    // the buffer absorbs the handshake round trip; when it fills, txReady drops
    fep_buf2 #(.W(PAIR_W), .DEPTH(2)) txBuf (
        .clk(clk),
        .rst(rst),
        .inValid(pairFull),
        .inData({pairHi, pairLo}),
        .inReady(bufInReady),
        .outValid(bufOutValid),
        .outData(bufOut),
        .outReady(bufOutReady)
    );

    // toggle handshake: txWord holds still until the link side answers
    always_comb begin
        busy = reqTog != ackS2;
        bufOutReady = !busy;
        next_txWord = txWord;
        next_reqTog = reqTog;
        if (bufOutValid && !busy) begin
            next_txWord = bufOut;
            next_reqTog = !reqTog;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txWord <= '0;
            reqTog <= 1'b0;
            ackS1 <= 1'b0;
            ackS2 <= 1'b0;
        end else begin
            txWord <= next_txWord;
            reqTog <= next_reqTog;
            ackS1 <= ackTog;
            ackS2 <= ackS1;
        end
    end

    // receive words arrive by toggle; the word is stable for a whole symbol,
    // which outlasts the three-flop detection here
    always_comb begin
        rxEdge = rxS2 ^ rxS3;
        rxWordNib = rxWord[NIB_W-1:0];
        next_rxData = rxData;
        next_rxDv = rxDv;
        next_rxEr = rxEr;
        if (rxEdge) begin
            next_rxData = rxWordNib;
            next_rxDv = rxWord[EN_BIT];
            next_rxEr = rxWord[ER_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxS1 <= 1'b0;
            rxS2 <= 1'b0;
            rxS3 <= 1'b0;
            lkS1 <= 1'b0;
            rxLock <= 1'b0;
            rxData <= '0;
            rxDv <= 1'b0;
            rxEr <= 1'b0;
            rxStrobe <= 1'b0;
        end else begin
            rxS1 <= rxTog;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
            lkS1 <= descLock;
            rxLock <= lkS1;
            rxData <= next_rxData;
            rxDv <= next_rxDv;
            rxEr <= next_rxEr;
            rxStrobe <= rxEdge;
        end
    end

    // reset and request cross into the link domain as levels
    always_ff @(posedge lineClk) begin
        lrs1 <= rst;
        lineRst <= lrs1;
        reqS1 <= reqTog;
        reqS2 <= reqS1;
    end

    fep_lfsr txScr (
        .clk(lineClk),
        .rst(lineRst),
        .load(1'b0),
        .inBit(1'b0),
        .key(txKey)
    );

    // symbol engine: J/K opens a frame, T/R closes it, idle fills the gaps;
    // an empty holding word mid-frame sends the error group rather than stall
    always_comb begin
        txTake = (reqS2 != ackTog) && !pendValid;
        txNib = halfSel ? pend[PAIR_W-1:WORD_W] : pend[WORD_W-1:0];
        next_ackTog = ackTog;
        next_pend = pend;
        next_pendValid = pendValid;
        next_halfSel = halfSel;
        next_txSt = txSt;
        next_bitCnt = (bitCnt == SYM_LAST) ? 3'h0 : bitCnt + 3'h1;
        next_sym = {sym[SYM_W-2:0], 1'b0};
        if (txTake) begin
            next_pend = txWord;
            next_pendValid = 1'b1;
            next_halfSel = 1'b0;
            next_ackTog = !ackTog;
        end
        if (bitCnt == SYM_LAST) begin
            unique case (txSt)
                TX_IDLE: begin
                    next_sym = SYM_I;
                    if (pendValid && txNib[EN_BIT]) begin
                        next_sym = SYM_J;
                        next_txSt = TX_K;
                    end else if (pendValid) begin
                        next_pendValid = 1'b0;
                    end
                end
                TX_K: begin
                    next_sym = SYM_K;
                    next_txSt = TX_DATA;
                end
                TX_DATA: begin
                    if (!pendValid) begin
                        next_sym = SYM_H;
                    end else if (txNib[EN_BIT]) begin
                        next_sym = txNib[ER_BIT] ? SYM_H : ENC_TAB[txNib[NIB_W-1:0]];
                        next_halfSel = !halfSel;
                        next_pendValid = !halfSel;
                    end else begin
                        next_sym = SYM_T;
                        next_txSt = TX_R;
                        next_pendValid = 1'b0;
                    end
                end
                TX_R: begin
                    next_sym = SYM_R;
                    next_txSt = TX_IDLE;
                end
            endcase
        end
        // coded bit, then scramble, then NRZI, then MLT-3
        scrBit = sym[SYM_W-1] ^ txKey;
        next_nrzi = nrzi ^ scrBit;
        // MLT-3 follows the NRZI register, so the line only steps where NRZI toggles
        next_mltPh = mltPh + {1'b0, next_nrzi ^ nrzi};
        if (next_mltPh == MLT_PH_POS) begin
            next_txLevel = LVL_POS;
        end else if (next_mltPh == MLT_PH_NEG) begin
            next_txLevel = LVL_NEG;
        end else begin
            next_txLevel = LVL_ZERO;
        end
    end

    always_ff @(posedge lineClk) begin
        if (lineRst) begin
            ackTog <= 1'b0;
            pend <= '0;
            pendValid <= 1'b0;
            halfSel <= 1'b0;
            txSt <= TX_IDLE;
            bitCnt <= 3'h0;
            sym <= SYM_I;
            nrzi <= 1'b0;
            mltPh <= 2'h0;
            txLevel <= LVL_ZERO;
        end else begin
            ackTog <= next_ackTog;
            pend <= next_pend;
            pendValid <= next_pendValid;
            halfSel <= next_halfSel;
            txSt <= next_txSt;
            bitCnt <= next_bitCnt;
            sym <= next_sym;
            nrzi <= next_nrzi;
            mltPh <= next_mltPh;
            txLevel <= next_txLevel;
        end
    end

    // until aligned the key register is fed from the line, assuming idle
    fep_lfsr rxScr (
        .clk(lineClk),
        .rst(lineRst),
        .load(!descLock),
        .inBit(!nrz),
        .key(rxKey)
    );

    // receive chain; lock drops after a run of bits with no transition
    always_comb begin
        next_rxNrzi = rxNrzi ^ (rxLevel != prevLvl);
        nrz = next_rxNrzi ^ rxNrzi;
        next_silent = nrz ? 6'h00 : ((silent == SILENT_MAX) ? silent : silent + 6'h01);
        next_locked = next_silent != SILENT_MAX;
        plain = nrz ^ rxKey;
        next_sh10 = {sh10[2*SYM_W-2:0], plain};
        symIn = next_sh10[SYM_W-1:0];
        dec = fepDecode(symIn);
        next_descLock = descLock;
        next_match = match;
        if (!locked) begin
            next_descLock = 1'b0;
            next_match = 6'h00;
        end else if (!descLock) begin
            next_match = (rxKey == !nrz) ? match + 6'h01 : 6'h00;
            next_descLock = match == SYNC_BITS;
        end
        next_rxSt = rxSt;
        next_rxCnt = (rxCnt == SYM_LAST) ? 3'h0 : rxCnt + 3'h1;
        next_rxWord = rxWord;
        next_rxTog = rxTog;
        unique case (rxSt)
            RX_HUNT: begin
                if (descLock && next_sh10 == {SYM_J, SYM_K}) begin
                    next_rxSt = RX_DATA;
                    next_rxCnt = 3'h0;
                end
            end
            RX_DATA: begin
                if (rxCnt == SYM_LAST) begin
                    next_rxTog = !rxTog;
                    if (symIn == SYM_T) begin
                        next_rxWord = WORD_END;
                        next_rxSt = RX_END;
                    end else if (symIn == SYM_I) begin
                        next_rxWord = WORD_BAD_END;
                        next_rxSt = RX_HUNT;
                    end else begin
                        next_rxWord = {1'b1, !dec[NIB_W], dec[NIB_W-1:0]};
                    end
                end
            end
            RX_END: begin
                if (rxCnt == SYM_LAST) begin
                    next_rxSt = RX_HUNT;
                end
            end
            default: begin
                next_rxSt = RX_HUNT;
            end
        endcase
        if (!descLock && rxSt != RX_DATA) begin
            next_rxSt = RX_HUNT;
        end
    end

    always_ff @(posedge lineClk) begin
        if (lineRst) begin
            prevLvl <= LVL_ZERO;
            rxNrzi <= 1'b0;
            silent <= SILENT_MAX;
            locked <= 1'b0;
            match <= 6'h00;
            descLock <= 1'b0;
            sh10 <= '0;
            rxSt <= RX_HUNT;
            rxCnt <= 3'h0;
            rxWord <= WORD_END;
            rxTog <= 1'b0;
        end else begin
            prevLvl <= rxLevel;
            rxNrzi <= next_rxNrzi;
            silent <= next_silent;
            locked <= next_locked;
            match <= next_match;
            descLock <= next_descLock;
            sh10 <= next_sh10;
            rxSt <= next_rxSt;
            rxCnt <= next_rxCnt;
            rxWord <= next_rxWord;
            rxTog <= next_rxTog;
        end
    end

    a_tx_kstart: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (bitCnt == SYM_LAST && txSt == TX_K) |=> (sym == SYM_K && txSt == TX_DATA))
        else $error("K group not sent after J");
    a_ser_period: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (bitCnt == 3'h0) |-> ##4 (bitCnt == SYM_LAST) ##1 (bitCnt == 3'h0))
        else $error("symbol period is not five bits");
    a_enc_data: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (bitCnt == SYM_LAST && txSt == TX_DATA && pendValid && txNib[EN_BIT]
            && !txNib[ER_BIT]) |=> (sym == ENC_TAB[$past(txNib[NIB_W-1:0])]))
        else $error("data nibble not coded");
    a_nrzi_out: assert property (
        @(posedge lineClk) disable iff (lineRst)
        scrBit |=> (nrzi != $past(nrzi)) && (mltPh == $past(mltPh) + 2'h1))
        else $error("one bit did not toggle NRZI");
    a_mlt_hold: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (!scrBit && !$past(lineRst)) |=> $stable(txLevel))
        else $error("line level moved on a zero bit");
    a_rx_nrzi: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (rxLevel != prevLvl) |=> (rxNrzi != $past(rxNrzi)))
        else $error("level change not seen as NRZI toggle");
    a_rx_lock: assert property (
        @(posedge lineClk) disable iff (lineRst)
        nrz |=> locked)
        else $error("transition did not qualify the bit clock");
    a_nrz_quiet: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (rxLevel == prevLvl) |-> !nrz)
        else $error("NRZ one without a line transition");
    a_rx_start: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (rxSt == RX_HUNT && descLock && next_sh10 == {SYM_J, SYM_K}) |=> rxSt == RX_DATA)
        else $error("J/K missed");
    a_descr_sync: assert property (
        @(posedge lineClk) disable iff (lineRst)
        $rose(descLock) |-> $past(match) == SYNC_BITS)
        else $error("de-scrambler locked early");
    a_rx_invalid: assert property (
        @(posedge lineClk) disable iff (lineRst)
        (rxSt == RX_DATA && rxCnt == SYM_LAST && !dec[NIB_W] && symIn != SYM_T
            && symIn != SYM_I) |=> (rxWord[EN_BIT] && rxWord[ER_BIT]))
        else $error("invalid group not flagged");
    a_rx_deliver: assert property (
        @(posedge clk) disable iff (rst)
        rxEdge |=> (rxStrobe && rxData == $past(rxWordNib)) ##1 !rxStrobe)
        else $error("receive word not delivered");
endmodule

// [tb/fep_line_partner.sv]
// line partner: loops transmitted levels back, or leaves the line silent
`timescale 1ns/10ps
module fep_line_partner
    import fep_pkg::*;
(
    input wire logic lineClk,
    input wire logic loopOn,
    input wire logic [1:0] txLevel,
    output logic [1:0] rxLevel
);
    // one bit of cable delay; a cut cable reads as the zero level
    initial rxLevel = LVL_ZERO;
    always @(posedge lineClk) begin
        rxLevel <= loopOn ? txLevel : LVL_ZERO;
    end
endmodule

// [tb/fep_pcs_datapath_tb.sv]
// bench: random MII frames looped back over the line and checked on receive
`timescale 1ns/10ps
module fep_pcs_datapath_tb
    import fep_pkg::*;
;
    logic clk = 0, lineClk = 0, rst = 1, txEn = 0, txEr = 0, loopOn = 1;
    logic [3:0] txData = 4'h0;
    logic txReady, rxDv, rxEr, rxStrobe, rxLock;
    logic [3:0] rxData;
    logic [1:0] txLevel, rxLevel, lastLvl, lastNz;
    logic [5:0] expQ [$];
    logic [5:0] e;
    int fails = 0, checks_done = 0, seed = 80044;

    // clk at 100 ns; link clock at 80 ns, its edges never meet the rising edges of clk
    always #50 clk = ~clk;
    always #40 lineClk = ~lineClk;

    fep_pcs_datapath DUT (.clk(clk), .rst(rst), .lineClk(lineClk), .txEn(txEn), .txEr(txEr),
        .txData(txData), .txReady(txReady), .rxData(rxData), .rxDv(rxDv), .rxEr(rxEr),
        .rxStrobe(rxStrobe), .rxLock(rxLock), .txLevel(txLevel), .rxLevel(rxLevel));
    fep_line_partner partner (.lineClk(lineClk), .loopOn(loopOn), .txLevel(txLevel),
        .rxLevel(rxLevel));

    task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // MLT-3 level expected after a change: zero after a peak, else the opposite peak
    function automatic logic [1:0] nextLvl(input logic [1:0] prev, input logic [1:0] nz);
        return (prev != LVL_ZERO) ? LVL_ZERO : ((nz == LVL_POS) ? LVL_NEG : LVL_POS);
    endfunction

    // bounded wait for the lock flag; a missing lock ends the run
    task automatic waitLock(input logic want);
        int n;
        n = 0;
        while (rxLock !== want && n < 3000) begin
            @(posedge clk);
            #10;
            n++;
        end
        check("rxLock", {5'h0, rxLock}, {5'h0, want});
        if (rxLock !== want) stop_test();
    endtask

    // present one nibble slot and hold it until an edge with txReady high takes it
    task automatic putNib(input logic en, input logic er, input logic [3:0] d);
        int n;
        n = 0;
        txEn = en;
        txEr = er;
        txData = d;
        while (txReady !== 1'b1 && n < 200) begin
            @(posedge clk);
            #10;
            n++;
        end
        check("txReady", {5'h0, txReady}, 6'h01);
        if (txReady !== 1'b1) stop_test();
        @(posedge clk);
        #10;
    endtask

    // line watcher: levels step only 0,+,0,- and never use the spare code;
    // looked at mid-period, where the registered level has settled
    always @(negedge lineClk) begin
        if (rst) begin
            lastLvl = LVL_ZERO;
            lastNz = LVL_NEG;
        end else if (txLevel !== lastLvl) begin
            check("txLevel", {4'h0, txLevel}, {4'h0, nextLvl(lastLvl, lastNz)});
            if (txLevel !== LVL_ZERO) lastNz = txLevel;
            lastLvl = txLevel;
        end
    end

    // receive words must match the sent ones in order; error words skip data;
    // sampled mid-cycle, away from the edge that launches the strobe
    always @(negedge clk) begin
        if (!rst && rxStrobe === 1'b1) begin
            if (expQ.size() == 0) begin
                check("rxExtra", 6'h01, 6'h00);
            end else begin
                e = expQ.pop_front();
                check("rxWord", {rxDv, rxEr, e[4] ? e[3:0] : rxData}, e);
            end
        end
    end

    initial begin
        int len;
        int n;
        logic [3:0] d;
        logic er;
        repeat (10) @(posedge clk);
        #10;
        rst = 0;
        check("txReady", {5'h0, txReady}, 6'h01);
        waitLock(1'b1);
        // cut the line: lock must drop, then return on the restored idle stream
        loopOn = 0;
        waitLock(1'b0);
        loopOn = 1;
        waitLock(1'b1);
        // frames of 1 and 2 nibbles first, then random lengths and gaps
        for (int f = 0; f < 12; f++) begin
            len = (f < 2) ? f + 1 : 1 + ($random(seed) & 15);
            for (int i = 0; i < len; i++) begin
                d = 4'($random(seed));
                er = (f == 3 && i == 0);
                expQ.push_back({1'b1, er, d});
                putNib(1'b1, er, d);
            end
            expQ.push_back(WORD_END);
            putNib(1'b0, 1'b0, 4'h0);
            // random gap; each step keeps the drive point just after the edge
            n = $random(seed) & 7;
            repeat (n) begin
                @(posedge clk);
                #10;
            end
        end
        n = 0;
        while (expQ.size() != 0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (50) @(posedge clk);
        check("rxPending", 6'(expQ.size()), 6'h00);
        stop_test();
    end
endmodule
